/* File: fambr_cfg.svh */
// constants for the flash address mode and bank select block
`ifndef FAMBR_CFG_SVH
`define FAMBR_CFG_SVH

// command codes
`define FAMBR_CMD_WRSR     8'h01
`define FAMBR_CMD_READ     8'h03
`define FAMBR_CMD_RDSR     8'h05
`define FAMBR_CMD_WREN     8'h06
`define FAMBR_CMD_RDBANK   8'h16
`define FAMBR_CMD_WRBANK   8'h17
`define FAMBR_CMD_RDPARAM  8'h5A
`define FAMBR_CMD_SRST     8'hF0

// address bank select register
`define FAMBR_BANK_RST     8'h00
`define FAMBR_BANK_4B_BIT  7
`define FAMBR_BANK_SEG_MSB 6

// first status register: bit 0 busy, bit 1 write enable latch, rest kept
`define FAMBR_SR1_WEL_BIT  1
`define FAMBR_SR1_NV_LSB   2
`define FAMBR_SR1_NV_RST   6'h00

// event indices across the link to system crossing
`define FAMBR_EV_WREN      0
`define FAMBR_EV_SRST      1
`define FAMBR_EV_BANK      2
`define FAMBR_EV_WRSR      3
`define FAMBR_EV_READ      4
`define FAMBR_EV_N         5

// parameter table contents
`define FAMBR_PT_DW16      8'h3C
`define FAMBR_DW16_B0      8'hF0
`define FAMBR_DW16_B1      8'h28
`define FAMBR_DW16_B2      8'hFA
`define FAMBR_DW16_B3      8'hA8
`define FAMBR_PT_SMAP      8'h40
`define FAMBR_SMAP_B0      8'hFF
`define FAMBR_SMAP_CFG_ID  8'h00
`define FAMBR_SMAP_RGN_CNT 8'h00
`define FAMBR_SMAP_B3      8'hFF
`define FAMBR_PT_BLANK     8'hFF

`endif

/* File: fambr_pkg.sv */
// types for the flash address mode and bank select block
package fambr_pkg;
    `include "fambr_cfg.svh"

    typedef enum logic [7:0] {
        FAMBR_WRSR    = `FAMBR_CMD_WRSR,
        FAMBR_READ    = `FAMBR_CMD_READ,
        FAMBR_RDSR    = `FAMBR_CMD_RDSR,
        FAMBR_WREN    = `FAMBR_CMD_WREN,
        FAMBR_RDBANK  = `FAMBR_CMD_RDBANK,
        FAMBR_WRBANK  = `FAMBR_CMD_WRBANK,
        FAMBR_RDPARAM = `FAMBR_CMD_RDPARAM,
        FAMBR_SRST    = `FAMBR_CMD_SRST
    } fambr_cmd_t;

    typedef enum logic [3:0] {
        PH_CMD   = 4'b0001,
        PH_ADDR  = 4'b0010,
        PH_DUMMY = 4'b0100,
        PH_DATA  = 4'b1000
    } fambr_phase_t;
endpackage

/* File: fambr_sync.sv */
// two flip-flop level synchroniser
`timescale 1ns/100ps
module fambr_sync #(
    parameter int WIDTH = 1
) (
    // destination clock
    input  wire logic             clk,
    // level from the far domain
    input  wire logic [WIDTH-1:0] din,
    // synchronised level
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk) begin
        meta_q <= din;
        dout   <= meta_q;
    end
endmodule

/* File: fambr_top.sv */
// flash address mode, bank select, soft reset and status write enable
// Operation
// - eight-bit volatile bank register supplies upper address bits 30..24 for 3-byte commands
// - bank bit 7 set selects 4-byte mode, full address from command
// - in 4-byte mode stored bank bits 6..0 are ignored
// - bank bit 7 clear: 3-byte mode, stored bits pick the 128 Mbit segment
// - command 16h returns the bank register on serial output
// - command 17h plus one data byte loads the bank register
// - hardware reset, software reset or power cycle return to 3-byte mode
// - single command F0h performs a software reset
// - first status register mixes volatile and nonvolatile bits
// - status write accepted only after 06h has set write enable
// - sector map shows one region, config id 00h, uniform 256 KB sectors
// - parameter word sixteen reads F0h, 28h, FAh, A8h in order
`timescale 1ns/100ps
`include "fambr_cfg.svh"
module fambr_top
    import fambr_pkg::*;
(
    // system side
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    // hardware reset pin
    input  wire logic        hw_reset_n,
    // serial link
    input  wire logic        spi_sck,
    input  wire logic        spi_cs_n,
    input  wire logic        spi_si,
    output logic             spi_so,
    output logic             spi_so_oe,
    // array side
    output logic             addr_4b_mode,
    output logic [6:0]       seg_sel,
    output logic [31:0]      array_addr,
    output logic             array_rd,
    output logic [7:0]       status1
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    // link domain
    logic [2:0]              bitpos_q;
    logic [6:0]              sh_q;
    logic [7:0]              rx_byte;
    logic                    byte_done;
    fambr_phase_t            ph_q;
    fambr_phase_t            ph_d;
    fambr_cmd_t              cmd_q;
    fambr_cmd_t              cmd_d;
    logic [23:0]             addr_q;
    logic [23:0]             addr_d;
    logic [1:0]              abyte_q;
    logic [1:0]              abyte_d;
    logic [7:0]              ptr_q;
    logic [7:0]              ptr_d;
    logic                    done_q;
    logic                    done_d;
    logic [7:0]              data_q;
    logic [31:0]             rd_addr_q;
    logic [`FAMBR_EV_N-1:0]  ev_tgl_q;
    logic [`FAMBR_EV_N-1:0]  ev_fire;
    logic                    tx_ld_q;
    logic                    tx_ld_d;
    logic [7:0]              tx_byte_q;
    logic [7:0]              tx_byte_d;
    logic [6:0]              tx_sh_q;
    logic [15:0]             sys_s;
    logic [7:0]              bank_s;
    logic [7:0]              sr1_s;
    logic                    mode4b_s;
    logic                    last_abyte;
    // system domain
    logic [7:0]              bank_q;
    logic                    wel_q;
    logic [5:0]              sr1_nv_q;
    logic [`FAMBR_EV_N-1:0]  ev_s;
    logic [`FAMBR_EV_N-1:0]  ev_prev_q;
    logic [`FAMBR_EV_N-1:0]  ev_p;
    logic                    hw_rst_s;
    logic                    any_reset;
    logic                    rd_q;
    logic [31:0]             arr_addr_q;

    ////////////////////////////////////////////////////////////////////////////
    // parameter table lookup
    function automatic logic [7:0] pt_byte(input logic [7:0] a);
        case (a)
            `FAMBR_PT_DW16:          pt_byte = `FAMBR_DW16_B0;
            `FAMBR_PT_DW16 + 8'h01:  pt_byte = `FAMBR_DW16_B1;
            `FAMBR_PT_DW16 + 8'h02:  pt_byte = `FAMBR_DW16_B2;
            `FAMBR_PT_DW16 + 8'h03:  pt_byte = `FAMBR_DW16_B3;
            `FAMBR_PT_SMAP:          pt_byte = `FAMBR_SMAP_B0;
            `FAMBR_PT_SMAP + 8'h01:  pt_byte = `FAMBR_SMAP_CFG_ID;
            `FAMBR_PT_SMAP + 8'h02:  pt_byte = `FAMBR_SMAP_RGN_CNT;
            `FAMBR_PT_SMAP + 8'h03:  pt_byte = `FAMBR_SMAP_B3;
            default:                 pt_byte = `FAMBR_PT_BLANK;
        endcase
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    // crossings
    // bank and status change only between frames; a read racing a write
    // in the same frame may see either value
    fambr_sync #(
        .WIDTH (16)
    ) u_to_link (
        .clk  (spi_sck),
        .din  ({status1, bank_q}),
        .dout (sys_s)
    );

    assign bank_s   = sys_s[7:0];
    assign sr1_s    = sys_s[15:8];
    assign mode4b_s = bank_s[`FAMBR_BANK_4B_BIT];
    fambr_sync #(
        .WIDTH (`FAMBR_EV_N)
    ) u_ev (
        .clk  (clk_sys),
        .din  (ev_tgl_q),
        .dout (ev_s)
    );

    fambr_sync #(
        .WIDTH (1)
    ) u_hw (
        .clk  (clk_sys),
        .din  (hw_reset_n),
        .dout (hw_rst_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // link: bit shifter
    assign byte_done = (bitpos_q == 3'h7);
    assign rx_byte   = {sh_q, spi_si};
    // chip select high restarts framing; sck may stop between frames
    always_ff @(posedge spi_sck or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            bitpos_q <= 3'h0;
            sh_q     <= 7'h00;
        end else begin
            bitpos_q <= bitpos_q + 3'h1;
            sh_q     <= rx_byte[6:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // link: command decode
    always_comb begin
        ph_d       = ph_q;
        cmd_d      = cmd_q;
        addr_d     = addr_q;
        abyte_d    = abyte_q;
        ptr_d      = ptr_q;
        done_d     = done_q;
        ev_fire    = '0;
        tx_ld_d    = 1'b0;
        tx_byte_d  = tx_byte_q;
        last_abyte = (cmd_q == FAMBR_READ && mode4b_s) ? (abyte_q == 2'h3)
                                                       : (abyte_q == 2'h2);
        if (byte_done) begin
            case (ph_q)
                PH_CMD: begin
                    cmd_d = fambr_cmd_t'(rx_byte);
                    ph_d  = PH_DATA;
                    case (rx_byte)
                        `FAMBR_CMD_WREN: ev_fire[`FAMBR_EV_WREN] = 1'b1;
                        `FAMBR_CMD_SRST: ev_fire[`FAMBR_EV_SRST] = 1'b1;
                        `FAMBR_CMD_RDBANK: begin
                            tx_ld_d   = 1'b1;
                            tx_byte_d = bank_s;
                        end
                        `FAMBR_CMD_RDSR: begin
                            tx_ld_d   = 1'b1;
                            tx_byte_d = sr1_s;
                        end
                        `FAMBR_CMD_READ, `FAMBR_CMD_RDPARAM: begin
                            ph_d    = PH_ADDR;
                            abyte_d = 2'h0;
                        end
                        default: ph_d = PH_DATA;
                    endcase
                end
                PH_ADDR: begin
                    addr_d  = {addr_q[15:0], rx_byte};
                    abyte_d = abyte_q + 2'h1;
                    if (last_abyte) begin
                        if (cmd_q == FAMBR_READ) begin
                            ev_fire[`FAMBR_EV_READ] = 1'b1;
                            ph_d = PH_DATA;
                        end else begin
                            ph_d = PH_DUMMY;
                        end
                    end
                end
                PH_DUMMY: begin
                    tx_ld_d   = 1'b1;
                    tx_byte_d = pt_byte(addr_q[7:0]);
                    ptr_d     = addr_q[7:0] + 8'h01;
                    ph_d      = PH_DATA;
                end
                PH_DATA: begin
                    case (cmd_q)
                        FAMBR_WRBANK: begin
                            // only the first data byte counts
                            ev_fire[`FAMBR_EV_BANK] = !done_q;
                            done_d = 1'b1;
                        end
                        FAMBR_WRSR: begin
                            ev_fire[`FAMBR_EV_WRSR] = !done_q;
                            done_d = 1'b1;
                        end
                        FAMBR_RDBANK: begin
                            tx_ld_d   = 1'b1;
                            tx_byte_d = bank_s;
                        end
                        FAMBR_RDSR: begin
                            tx_ld_d   = 1'b1;
                            tx_byte_d = sr1_s;
                        end
                        FAMBR_RDPARAM: begin
                            tx_ld_d   = 1'b1;
                            tx_byte_d = pt_byte(ptr_q);
                            ptr_d     = ptr_q + 8'h01;
                        end
                        default: done_d = done_q;
                    endcase
                end
                default: ph_d = PH_CMD;
            endcase
        end
    end

    always_ff @(posedge spi_sck or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            ph_q      <= PH_CMD;
            cmd_q     <= FAMBR_READ;
            addr_q    <= 24'h00_0000;
            abyte_q   <= 2'h0;
            ptr_q     <= 8'h00;
            done_q    <= 1'b0;
            tx_ld_q   <= 1'b0;
            tx_byte_q <= 8'h00;
        end else begin
            ph_q      <= ph_d;
            cmd_q     <= cmd_d;
            addr_q    <= addr_d;
            abyte_q   <= abyte_d;
            ptr_q     <= ptr_d;
            done_q    <= done_d;
            tx_ld_q   <= tx_ld_d;
            tx_byte_q <= tx_byte_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // link: event toggles and held data
    // toggles must survive chip select, so only power reset clears them
    always_ff @(posedge spi_sck or negedge rstn) begin
        if (!rstn) begin
            ev_tgl_q <= '0;
        end else begin
            ev_tgl_q <= ev_tgl_q ^ ev_fire;
        end
    end
    // held until the next event; system side samples well before then
    always_ff @(posedge spi_sck or negedge rstn) begin
        if (!rstn) begin
            data_q    <= 8'h00;
            rd_addr_q <= 32'h0000_0000;
        end else begin
            if (ev_fire[`FAMBR_EV_BANK] || ev_fire[`FAMBR_EV_WRSR]) begin
                data_q <= rx_byte;
            end
            if (ev_fire[`FAMBR_EV_READ]) begin
                if (mode4b_s) begin
                    rd_addr_q <= {addr_q, rx_byte};
                end else begin
                    rd_addr_q <= {1'b0, bank_s[`FAMBR_BANK_SEG_MSB:0],
                                  addr_q[15:0], rx_byte};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // link: serial output, mode 0, shifted on the falling edge
    always_ff @(negedge spi_sck or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            spi_so    <= 1'b0;
            spi_so_oe <= 1'b0;
            tx_sh_q   <= 7'h00;
        end else if (tx_ld_q) begin
            spi_so    <= tx_byte_q[7];
            spi_so_oe <= 1'b1;
            tx_sh_q   <= tx_byte_q[6:0];
        end else begin
            spi_so    <= tx_sh_q[6];
            tx_sh_q   <= {tx_sh_q[5:0], 1'b0};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // system: event edges and reset sources
    assign ev_p = ev_s ^ ev_prev_q;
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ev_prev_q <= '0;
        end else begin
            ev_prev_q <= ev_s;
        end
    end

    // the host has already left continuous quad read before a reset
    assign any_reset = !hw_rst_s || ev_p[`FAMBR_EV_SRST];

    ////////////////////////////////////////////////////////////////////////////
    // system: address bank select register
    always_ff @(posedge clk_sys) begin
        if (!rstn || any_reset) begin
            bank_q <= `FAMBR_BANK_RST;
        end else if (ev_p[`FAMBR_EV_BANK]) begin
            bank_q <= data_q;
        end
    end

    assign addr_4b_mode = bank_q[`FAMBR_BANK_4B_BIT];
    assign seg_sel      = bank_q[`FAMBR_BANK_SEG_MSB:0];

    ////////////////////////////////////////////////////////////////////////////
    // system: first status register
    // write enable latch is volatile: any reset clears it; set beats clear
    always_ff @(posedge clk_sys) begin
        if (!rstn || any_reset) begin
            wel_q <= 1'b0;
        end else if (ev_p[`FAMBR_EV_WREN]) begin
            wel_q <= 1'b1;
        end else if (ev_p[`FAMBR_EV_WRSR]) begin
            wel_q <= 1'b0;
        end
    end
    // upper bits are kept across hardware and software reset
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            sr1_nv_q <= `FAMBR_SR1_NV_RST;
        end else if (ev_p[`FAMBR_EV_WRSR] && wel_q) begin
            sr1_nv_q <= data_q[7:`FAMBR_SR1_NV_LSB];
        end
    end

    assign status1 = {sr1_nv_q, wel_q, 1'b0};
    ////////////////////////////////////////////////////////////////////////////
    // system: array read request
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rd_q       <= 1'b0;
            arr_addr_q <= 32'h0000_0000;
        end else begin
            rd_q <= ev_p[`FAMBR_EV_READ];
            if (ev_p[`FAMBR_EV_READ]) begin
                arr_addr_q <= rd_addr_q;
            end
        end
    end

    assign array_rd   = rd_q;
    assign array_addr = arr_addr_q;
endmodule

/* File: fambr_top_properties.sv */
// concurrent checks on the ports of the address mode and bank block
`timescale 1ns/100ps
module fambr_top_properties (
    // system side
    input wire logic        clk_sys,
    input wire logic        rstn,
    input wire logic        hw_reset_n,
    // link
    input wire logic        spi_cs_n,
    input wire logic        spi_so_oe,
    // array side
    input wire logic        addr_4b_mode,
    input wire logic [6:0]  seg_sel,
    input wire logic [31:0] array_addr,
    input wire logic        array_rd,
    input wire logic [7:0]  status1
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    property p_rst;
        disable iff (1'b0) !rstn |=> status1 == 8'h00 && !addr_4b_mode && seg_sel == 7'h00;
    endproperty
    a_rst: assert property (p_rst) else $error("state not cleared by reset");
    property p_hw;
        !hw_reset_n [*4] |-> !addr_4b_mode && seg_sel == 7'h00 && !status1[1];
    endproperty
    a_hw: assert property (p_hw) else $error("hardware reset kept bank");
    property p_busy;
        status1[0] == 1'b0;
    endproperty
    a_busy: assert property (p_busy) else $error("busy bit set");
    property p_seg;
        array_rd && !addr_4b_mode |-> array_addr[31:24] == {1'b0, seg_sel};
    endproperty
    a_seg: assert property (p_seg) else $error("segment not applied");
    property p_pulse;
        array_rd |=> !array_rd && $stable(array_addr);
    endproperty
    a_pulse: assert property (p_pulse) else $error("read strobe too long");
    property p_oe;
        spi_cs_n |-> !spi_so_oe;
    endproperty
    a_oe: assert property (p_oe) else $error("output driven while deselected");
    property p_nv;
        $changed(status1[7:2]) && $past(rstn) |-> $past(status1[1]);
    endproperty
    a_nv: assert property (p_nv) else $error("status written without enable");
    property p_bank_hold;
        $changed({addr_4b_mode, seg_sel}) |=> $stable({addr_4b_mode, seg_sel}) [*2];
    endproperty
    a_bank_hold: assert property (p_bank_hold) else $error("bank changed twice");

    c_rd4: cover property (array_rd && addr_4b_mode);
    c_oe: cover property ($rose(spi_so_oe));
    c_wel: cover property ($fell(status1[1]));
endmodule

bind fambr_top fambr_top_properties u_props (.clk_sys(clk_sys), .rstn(rstn),
    .hw_reset_n(hw_reset_n), .spi_cs_n(spi_cs_n), .spi_so_oe(spi_so_oe),
    .addr_4b_mode(addr_4b_mode), .seg_sel(seg_sel), .array_addr(array_addr),
    .array_rd(array_rd), .status1(status1));

/* File: fambr_host.sv */
// serial host model driving the flash link
`timescale 1ns/100ps
module fambr_host (
    // link out
    output logic      spi_sck,
    output logic      spi_cs_n,
    output logic      spi_si,
    // link in
    input wire logic  spi_so
);
    logic [7:0] rx_q;

    initial begin
        spi_sck = 1'b0;
        spi_cs_n = 1'b1;
        spi_si = 1'b0;
        rx_q = 8'h00;
    end

    // one command per frame; never enters quad mode, so no exit needed
    // write commands carry their single data byte here
    task automatic frame(input logic [7:0] tx[$], input bit rd);
        logic [7:0] b;
        spi_cs_n = 1'b0;
        foreach (tx[i]) begin
            b = tx[i];
            for (int k = 7; k >= 0; k--) begin
                spi_si = b[k];
                #15 spi_sck = 1'b1;
                #15 spi_sck = 1'b0;
            end
        end
        for (int k = 0; k < (rd ? 8 : 0); k++) begin
            spi_si = ~spi_si;
            #15 spi_sck = 1'b1;
            rx_q = {rx_q[6:0], spi_so};
            #15 spi_sck = 1'b0;
        end
        // clock stands still between frames, data line left toggled
        #15 spi_cs_n = 1'b1;
        spi_si = ~spi_si;
        #15;
    endtask
endmodule

/* File: test_flash_address_mode_bank_reg.sv */
// self-checking bench for the address mode and bank select block
`timescale 1ns/100ps
module test_flash_address_mode_bank_reg;
    import fambr_pkg::*;
    logic        clk_sys, rstn, hw_reset_n;
    logic        spi_sck, spi_cs_n, spi_si, spi_so, spi_so_oe;
    logic        addr_4b_mode, array_rd;
    logic [6:0]  seg_sel;
    logic [31:0] array_addr, v, a;
    logic [7:0]  status1, bank;
    logic [5:0]  nv;
    logic        wel;
    int          n_fail, samples_checked, seed;
    int          n_rd, n_oe;
    logic [7:0]  tbl [8] = '{8'hF0, 8'h28, 8'hFA, 8'hA8, 8'hFF, 8'h00, 8'h00, 8'hFF};

    fambr_top uut (.clk_sys(clk_sys), .rstn(rstn), .hw_reset_n(hw_reset_n),
        .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so(spi_so),
        .spi_so_oe(spi_so_oe), .addr_4b_mode(addr_4b_mode), .seg_sel(seg_sel),
        .array_addr(array_addr), .array_rd(array_rd), .status1(status1));
    fambr_host host (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
        .spi_so(spi_so));

    // strobe and enable activity, compared against command counts
    always @(posedge clk_sys) begin
        if (array_rd === 1'b1)
            n_rd++;
    end
    always @(posedge spi_so_oe)
        n_oe++;

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // events need up to 4 system cycles to land
    task automatic send(input logic [7:0] tx[$], input bit rd);
        host.frame(tx, rd);
        repeat (5) @(posedge clk_sys);
        #1;
    endtask

    task automatic chk_state();
        int k;
        check("addr_4b_mode", addr_4b_mode, bank[7]);
        check("seg_sel", seg_sel, bank[6:0]);
        check("status1", status1, {nv, wel, 1'b0});
        k = n_oe;
        send('{8'h16}, 1'b1);
        check("bank_read", host.rx_q, bank);
        check("so_oe_rise", n_oe, k + 1);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        #1_000_000;
        n_fail++;
        complete_run();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        // start high so the drop is a real edge for the link toggles
        rstn = 1'b1;
        hw_reset_n = 1'b1;
        seed = 32'h86fd_9cff;
        bank = 8'h00;
        wel = 1'b0;
        nv = 6'h00;
        #1 rstn = 1'b0;
        repeat (4) @(posedge clk_sys);
        #1 rstn = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        chk_state();
        for (int i = 0; i < 4; i++) begin
            v = $random(seed);
            a = $random(seed);
            bank = {i[0], v[6:0]};
            // trailing byte after the data byte must be ignored
            send('{8'h17, bank, ~v[7:0]}, 1'b0);
            chk_state();
            if (bank[7])
                send('{8'h03, a[31:24], a[23:16], a[15:8], a[7:0]}, 1'b0);
            else
                send('{8'h03, a[23:16], a[15:8], a[7:0]}, 1'b0);
            check("array_addr", array_addr, bank[7] ? a : {1'b0, bank[6:0], a[23:0]});
            check("array_rd", n_rd, i + 1);
        end
        send('{8'h06}, 1'b0);
        wel = 1'b1;
        chk_state();
        send('{8'hF0}, 1'b0);
        bank = 8'h00;
        wel = 1'b0;
        chk_state();
        v = $random(seed);
        send('{8'h01, v[7:0]}, 1'b0);
        chk_state();
        send('{8'h06}, 1'b0);
        send('{8'h01, v[7:0]}, 1'b0);
        nv = v[7:2];
        chk_state();
        send('{8'h05}, 1'b1);
        check("status_read", host.rx_q, {nv, wel, 1'b0});
        bank = 8'hC5;
        send('{8'h17, bank}, 1'b0);
        send('{8'h06}, 1'b0);
        hw_reset_n = 1'b0;
        repeat (5) @(posedge clk_sys);
        #1 hw_reset_n = 1'b1;
        bank = 8'h00;
        wel = 1'b0;
        chk_state();
        for (int j = 0; j < 8; j++) begin
            send('{8'h5A, 8'h00, 8'h00, 8'(8'h3C + j), 8'hFF}, 1'b1);
            check("table", host.rx_q, tbl[j]);
        end
        send('{8'h17, 8'h85}, 1'b0);
        rstn = 1'b0;
        repeat (4) @(posedge clk_sys);
        #1 rstn = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        bank = 8'h00;
        nv = 6'h00;
        chk_state();
        complete_run();
    end
endmodule
